/* bench/phsc_bench.sv */
`timescale 1ns/1ps
// Bench: host frames, register reads and detector pulses
module phsc_bench;
   logic        clock = 0, resetn = 0, pd_n = 1, mode_n = 1, pfd = 0, fo = 0, rd = 0;
   logic        ref_e = 0, fb_e = 0, wr_s = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [15:0] diff = 16'h0000;
   logic [31:0] seed = 32'he007, w;
   wire  logic  sck, sda, sle, tri_o, neg, cc, stat, lock, pre, alm;
   wire  logic [31:0] rdata;
   wire  logic [9:0]  en, inv, sh, ra;
   int          miscompares = 0, n_checks = 0;
   always #4 clock = ~clock;
   phsc_host host (.clock(clock), .sck(sck), .sda(sda), .sle(sle));
   phsc_top dut (.clock(clock), .resetn(resetn), .clock_enable(1'b1), .serial_clock(sck), .serial_data(sda),
      .serial_latch_enable(sle), .power_down_pin_n(pd_n), .mode_pin_n(mode_n), .analog_lock(1'b0), .ref_valid(1'b1),
      .ref_edge(ref_e), .fb_edge(fb_e), .pfd_sample(pfd), .phase_diff_ps(diff), .freq_offset(fo), .reg_addr(adr),
      .reg_wdata(wd), .reg_write(wr_s), .reg_read(rd), .reg_rdata(rdata), .cp_tristate(tri_o),
      .cp_preset(pre), .cp_negative(neg), .counters_clear(cc), .power_down_active(), .pll_lock_digital(lock),
      .analog_lock_mode(alm), .clock_outputs_enable(en), .clock_outputs_invert(inv), .clock_outputs_shift90(sh),
      .clock_outputs_ref_aligned(ra), .clock_outputs_static(stat));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Read data stands one cycle only, so it is taken right then
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clock) {rd, adr} <= {1'b1, a};
      @(posedge clock) rd <= 1'b0;
      #1 chk(n, e, rdata & m);
   endtask
   // One-cycle register write; the strobe drops on the next edge
   task automatic wrc(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) {wr_s, adr, wd} <= {1'b1, a, d};
      @(posedge clock) wr_s <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      rdc("word3", phsc_pkg::REG_WORD3, phsc_pkg::WORD3_DEFAULT, '1);
      rdc("unmapped", 8'h20, 32'h0000_0000, '1);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         w = (k == 0) ? 32'h0FFF_FFFE : {4'h0, seed[27:2], 2'h2};
         host.send(w, 32);
         rdc("word2", phsc_pkg::REG_WORD2, w, '1);
         chk("outputs", {w[23:14], ~w[13:4], 10'h0, w[3:2]}, {inv, en, 10'h0, pre, neg});
      end
      host.send(32'h0000_0006, 31);
      rdc("dropped", phsc_pkg::REG_STATUS, 32'h0000_0080, 32'h0000_0080);
      rdc("kept", phsc_pkg::REG_WORD2, w, '1);
      @(posedge clock) mode_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("reset mode", 32'h0000_0007, {29'h0, cc, stat, tri_o});
      @(posedge clock) mode_n <= 1'b1;
      rdc("settings", phsc_pkg::REG_WORD2, w, '1);
      @(posedge clock) pd_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("pd outputs", 32'h0000_0001, {21'h0, en, tri_o});
      @(posedge clock) pd_n <= 1'b1;
      rdc("defaults", phsc_pkg::REG_WORD2, phsc_pkg::WORD2_DEFAULT, '1);
      // Outputs 0 and 2 on the quarter divider, feedback taken from it too
      wrc(phsc_pkg::REG_ROUTE, 32'h0000_0405);
      host.send(32'h6000_0005, 32);
      repeat (2) @(posedge clock);
      #1 chk("phase", 32'h0405_0005, {5'h0, alm, sh, 6'h0, ra});
      // External hold by register bit, released only after both detector edges
      host.send(32'h8000_0002, 32);
      repeat (2) @(posedge clock);
      #1 chk("hold set", 32'h0000_0001, {31'h0, tri_o});
      host.send(32'h0000_0002, 32);
      repeat (3) @(posedge clock);
      @(posedge clock) ref_e <= 1'b1;
      @(posedge clock) {ref_e, fb_e} <= 2'b01;
      #1 chk("hold kept", 32'h0000_0001, {31'h0, tri_o});
      @(posedge clock) fb_e <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("hold released", 32'h0000_0000, {31'h0, tri_o});
      host.send(32'h0000_0003, 32);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) host.send(32'h0000_004F, 32);
         @(posedge clock) {pfd, fo, diff} <= {1'b1, i == 3, (i == 0) ? phsc_pkg::HALF_3P5_PS :
            (i == 1) ? phsc_pkg::HALF_3P5_PS + 16'h0001 + {1'b0, seed[14:0]} : 16'hFFFF};
         @(posedge clock) {pfd, diff} <= {1'b0, ~diff};
         repeat (2) @(posedge clock);
         #1 chk("lock", {31'h0, !i[0]}, {31'h0, lock});
      end
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge clock);
      miscompares++;
      stop_test;
   end
endmodule
bind phsc_top phsc_top_monitor mon (.clock(clock), .resetn(resetn), .mode_pin_n(mode_pin_n), .pfd_sample(pfd_sample),
   .phase_diff_ps(phase_diff_ps), .freq_offset(freq_offset), .cp_tristate(cp_tristate), .cp_negative(cp_negative),
   .counters_clear(counters_clear), .power_down_active(power_down_active), .pll_lock_digital(pll_lock_digital),
   .clock_outputs_static(clock_outputs_static));

/* bench/phsc_host.sv */
`timescale 1ns/1ps
// Host on the write-only port; no answer comes back, clock idles low
module phsc_host (
   input  wire logic clock,
   output logic      sck,
   output logic      sda,
   output logic      sle
);
   initial {sck, sda, sle} = 3'b001;
   // Each level lasts two clocks so the sampler sees every edge
   task automatic send(input logic [31:0] w, input int n);
      @(posedge clock) sle <= 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         @(posedge clock) {sck, sda} <= {1'b0, w[i]};
         @(posedge clock);
         @(posedge clock) sck <= 1'b1;
         @(posedge clock);
      end
      @(posedge clock) {sck, sda} <= {1'b0, ~sda};
      @(posedge clock) sle <= 1'b1;
   endtask
endmodule

/* bench/phsc_top_monitor.sv */
`timescale 1ns/1ps
// Pin checks of pump, power and lock; clock enable is taken as high
module phsc_top_monitor (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        mode_pin_n,
   input wire logic        pfd_sample,
   input wire logic [15:0] phase_diff_ps,
   input wire logic        freq_offset,
   input wire logic        cp_tristate,
   input wire logic        cp_negative,
   input wire logic        counters_clear,
   input wire logic        power_down_active,
   input wire logic        pll_lock_digital,
   input wire logic        clock_outputs_static
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Word restore lands a cycle late, so direction is judged after two
   property p_pd_pump; power_down_active |=> cp_tristate; endproperty
   a_pd_pump: assert property (p_pd_pump) else $error("pd pump");
   property p_pd_stat; power_down_active |=> counters_clear && clock_outputs_static; endproperty
   a_pd_stat: assert property (p_pd_stat) else $error("pd static");
   property p_pd_dir; power_down_active [*2] |=> !cp_negative; endproperty
   a_pd_dir: assert property (p_pd_dir) else $error("pd direction");
   property p_pin; !mode_pin_n |=> cp_tristate; endproperty
   a_pin: assert property (p_pin) else $error("pin pump");
   property p_clr; counters_clear |-> cp_tristate; endproperty
   a_clr: assert property (p_clr) else $error("clear pump");
   property p_pair; counters_clear == clock_outputs_static; endproperty
   a_pair: assert property (p_pair) else $error("static pair");
   property p_rise; $rose(pll_lock_digital) |-> $past(pfd_sample) || $past(pfd_sample, 2); endproperty
   a_rise: assert property (p_rise) else $error("lock rise");
   // Lock pin is one register behind the detector, so the drop shows two edges later
   property p_loss; pfd_sample && freq_offset && phase_diff_ps > phsc_pkg::HALF_18P5_PS |-> ##2 !pll_lock_digital; endproperty
   a_loss: assert property (p_loss) else $error("lock loss");
endmodule

/* design/phsc_top.sv */
`timescale 1ns/1ps
module phsc_top #(
   parameter int NUM_OUT = 10
) (
   input  wire logic                 clock,
   input  wire logic                 resetn,
   input  wire logic                 clock_enable,
   // Serial configuration port
   input  wire logic                 serial_clock,
   input  wire logic                 serial_data,
   input  wire logic                 serial_latch_enable,
   // Device pins
   input  wire logic                 power_down_pin_n,
   input  wire logic                 mode_pin_n,
   input  wire logic                 analog_lock,
   // Detector events
   input  wire logic                 ref_valid,
   input  wire logic                 ref_edge,
   input  wire logic                 fb_edge,
   input  wire logic                 pfd_sample,
   input  wire logic [15:0]          phase_diff_ps,
   input  wire logic                 freq_offset,
   // Local register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   output logic      [31:0]          reg_rdata,
   // Control outputs
   output logic                      cp_tristate,
   output logic                      cp_preset,
   output logic                      cp_negative,
   output logic                      counters_clear,
   output logic                      power_down_active,
   output logic                      pll_lock_digital,
   output logic                      analog_lock_mode,
   output logic      [NUM_OUT-1:0]   clock_outputs_enable,
   output logic      [NUM_OUT-1:0]   clock_outputs_invert,
   output logic      [NUM_OUT-1:0]   clock_outputs_shift90,
   output logic      [NUM_OUT-1:0]   clock_outputs_ref_aligned,
   output logic                      clock_outputs_static
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [31:0]                 word_reg [phsc_pkg::NUM_WORDS];
   logic [31:0]                 shift_reg;
   logic [5:0]                  bitcnt_reg;
   logic                        sclk_prev_reg;
   logic                        le_prev_reg;
   logic                        in_xfer_reg;
   logic [NUM_OUT:0]            route_reg;
   logic [8:0]                  lock_cnt_reg;
   logic                        lock_reg;
   logic                        lost_reg;
   phsc_pkg::phsc_ho_state_t    ho_state_reg;
   logic [6:0]                  relock_cnt_reg;
   logic                        ext_hold_reg;
   logic                        ext_ref_seen_reg;
   logic                        ext_fb_seen_reg;
   logic                        xfer_drop_reg;
   logic [31:0]                 rdata_next;
   logic [8:0]                  lock_target;
   logic [15:0]                 half_window;
   logic                        inside_window;
   logic                        sclk_rise;
   logic                        le_fall;
   logic                        le_rise;
   logic                        pin_hold;
   logic                        pin_reset;
   logic                        ext_hold_req;
   logic                        reset_mode;
   logic                        ho_armed;
   logic                        quarter_mode;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   // One multipurpose pin serves either as hold or as reset input
   assign pin_hold     = word_reg[2][phsc_pkg::W2_PIN_IS_HOLD] & ~mode_pin_n;
   assign pin_reset    = ~word_reg[2][phsc_pkg::W2_PIN_IS_HOLD] & ~mode_pin_n;
   assign ext_hold_req = pin_hold | word_reg[2][phsc_pkg::W2_SOFT_HOLD];
   assign reset_mode   = pin_reset | word_reg[2][phsc_pkg::W2_SOFT_RESET];
   assign power_down_active = ~power_down_pin_n | word_reg[2][phsc_pkg::W2_POWER_DOWN];
   // Hold is armed always, or only while the analog lock output is high
   assign ho_armed = word_reg[3][phsc_pkg::W3_HOLD_FUNC]
                     & (word_reg[3][phsc_pkg::W3_HOLD_ALWAYS] | analog_lock);
   assign quarter_mode = word_reg[1][phsc_pkg::W1_P16_DIV4] | word_reg[1][phsc_pkg::W1_P16_DIV8];

   // Serial pins are synchronous to clock, so plain edge detection suffices
   assign sclk_rise = serial_clock & ~sclk_prev_reg;
   assign le_fall   = ~serial_latch_enable & le_prev_reg;
   assign le_rise   = serial_latch_enable & ~le_prev_reg;

   // ---------------------------------------------------------------
   // Serial pin history
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sclk_prev_reg <= 1'b0;
         le_prev_reg   <= 1'b1;
      end else if (clock_enable) begin
         sclk_prev_reg <= serial_clock;
         le_prev_reg   <= serial_latch_enable;
      end
   end

   // ---------------------------------------------------------------
   // Serial shifter
   // ---------------------------------------------------------------
   // Counter saturates so an over-long frame stays detectable
   always_ff @(posedge clock) begin
      if (!resetn) begin
         shift_reg   <= '0;
         bitcnt_reg  <= '0;
         in_xfer_reg <= 1'b0;
      end else if (clock_enable) begin
         if (le_fall) begin
            in_xfer_reg <= 1'b1;
            bitcnt_reg  <= '0;
         end else if (le_rise || serial_latch_enable) begin
            in_xfer_reg <= 1'b0;
         end else if (in_xfer_reg && sclk_rise) begin
            shift_reg <= {shift_reg[30:0], serial_data};
            if (bitcnt_reg != phsc_pkg::BITCNT_MAX) begin
               bitcnt_reg <= bitcnt_reg + 6'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration words
   // ---------------------------------------------------------------
   // Power-down restores defaults, which also clears its own register bit.
   // The serial port never answers the host: writes only.
   always_ff @(posedge clock) begin
      if (!resetn || (clock_enable && power_down_active)) begin
         word_reg[0]   <= phsc_pkg::WORD0_DEFAULT;
         word_reg[1]   <= phsc_pkg::WORD1_DEFAULT;
         word_reg[2]   <= phsc_pkg::WORD2_DEFAULT;
         word_reg[3]   <= phsc_pkg::WORD3_DEFAULT;
         xfer_drop_reg <= 1'b0;
      end else if (clock_enable && le_rise && in_xfer_reg) begin
         if (bitcnt_reg == phsc_pkg::BITS_PER_WORD) begin
            word_reg[shift_reg[phsc_pkg::ADDR_FIELD_W-1:0]] <= shift_reg;
         end else begin
            xfer_drop_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Lock detector
   // ---------------------------------------------------------------
   always_comb begin
      unique case (word_reg[3][phsc_pkg::W3_WINDOW_LSB +: 2])
         phsc_pkg::WIN_3P5:  half_window = phsc_pkg::HALF_3P5_PS;
         phsc_pkg::WIN_8P5:  half_window = phsc_pkg::HALF_8P5_PS;
         phsc_pkg::WIN_18P5: half_window = phsc_pkg::HALF_18P5_PS;
         phsc_pkg::WIN_FREQ: half_window = 16'hFFFF;
      endcase
      unique case (word_reg[3][phsc_pkg::W3_COUNT_LSB +: 2])
         2'h0: lock_target = phsc_pkg::LOCK_CNT_0;
         2'h1: lock_target = phsc_pkg::LOCK_CNT_1;
         2'h2: lock_target = phsc_pkg::LOCK_CNT_2;
         2'h3: lock_target = phsc_pkg::LOCK_CNT_3;
      endcase
      // Frequency offset only counts when cycle slip detection is on, or as criterion
      inside_window = (phase_diff_ps <= half_window)
                      && !(freq_offset && (word_reg[3][phsc_pkg::W3_CYCLE_SLIP]
                           || word_reg[3][phsc_pkg::W3_WINDOW_LSB +: 2] == phsc_pkg::WIN_FREQ));
   end

   // A single bad cycle drops lock at once; the count gates only the rising side
   always_ff @(posedge clock) begin
      if (!resetn || (clock_enable && (power_down_active || reset_mode))) begin
         lock_cnt_reg <= '0;
         lock_reg     <= 1'b0;
         lost_reg     <= 1'b0;
      end else if (clock_enable) begin
         lost_reg <= 1'b0;
         if (pfd_sample) begin
            if (!inside_window) begin
               lock_cnt_reg <= '0;
               lock_reg     <= 1'b0;
               lost_reg     <= lock_reg;
            end else if (lock_cnt_reg < lock_target) begin
               if (lock_cnt_reg + 9'h001 == lock_target) begin
                  lock_reg <= 1'b1;
               end
               lock_cnt_reg <= lock_cnt_reg + 9'h001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Automatic hold-over sequence
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn || (clock_enable && (power_down_active || reset_mode))) begin
         ho_state_reg   <= phsc_pkg::HO_IDLE;
         relock_cnt_reg <= '0;
      end else if (clock_enable) begin
         if (!ho_armed) begin
            ho_state_reg <= phsc_pkg::HO_IDLE;
         end else begin
            unique case (ho_state_reg)
               phsc_pkg::HO_IDLE: begin
                  if (lock_reg) begin
                     ho_state_reg <= phsc_pkg::HO_LOCKED;
                  end
               end
               phsc_pkg::HO_LOCKED: begin
                  if (lost_reg) begin
                     ho_state_reg <= phsc_pkg::HO_HOLD;
                  end
               end
               phsc_pkg::HO_HOLD: begin
                  if (ref_valid) begin
                     ho_state_reg   <= phsc_pkg::HO_RELOCK;
                     relock_cnt_reg <= '0;
                  end
               end
               phsc_pkg::HO_RELOCK: begin
                  if (pfd_sample) begin
                     if (relock_cnt_reg + 7'h01 == phsc_pkg::RELOCK_CYCLES) begin
                        ho_state_reg <= phsc_pkg::HO_IDLE;
                     end
                     relock_cnt_reg <= relock_cnt_reg + 7'h01;
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // External hold with release on next reference and feedback edge
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ext_hold_reg     <= 1'b0;
         ext_ref_seen_reg <= 1'b0;
         ext_fb_seen_reg  <= 1'b0;
      end else if (clock_enable) begin
         if (ext_hold_req) begin
            ext_hold_reg     <= 1'b1;
            ext_ref_seen_reg <= 1'b0;
            ext_fb_seen_reg  <= 1'b0;
         end else if (ext_hold_reg) begin
            ext_ref_seen_reg <= ext_ref_seen_reg | ref_edge;
            ext_fb_seen_reg  <= ext_fb_seen_reg | fb_edge;
            if ((ext_ref_seen_reg || ref_edge) && (ext_fb_seen_reg || fb_edge)) begin
               ext_hold_reg <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Pump and output controls
   // ---------------------------------------------------------------
   // Registered so every control pin except the combinational power_down_active changes on a clean edge
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cp_tristate          <= 1'b1;
         cp_preset            <= 1'b0;
         cp_negative          <= 1'b0;
         counters_clear       <= 1'b1;
         pll_lock_digital     <= 1'b0;
         analog_lock_mode     <= 1'b0;
         clock_outputs_enable <= '0;
         clock_outputs_invert <= '0;
         clock_outputs_static <= 1'b1;
      end else if (clock_enable) begin
         cp_tristate <= power_down_active | reset_mode | ext_hold_req | ext_hold_reg
                        | (ho_state_reg == phsc_pkg::HO_HOLD);
         cp_preset        <= word_reg[2][phsc_pkg::W2_CP_PRESET];
         cp_negative      <= word_reg[2][phsc_pkg::W2_CP_NEGATIVE];
         counters_clear   <= power_down_active | reset_mode;
         pll_lock_digital <= lock_reg & ~power_down_active;
         analog_lock_mode <= word_reg[1][phsc_pkg::W1_ANALOG_LOCK];
         clock_outputs_enable <= ~word_reg[2][phsc_pkg::W2_DISABLE_LSB +: NUM_OUT]
                                 & {NUM_OUT{~power_down_active}};
         clock_outputs_invert <= word_reg[2][phsc_pkg::W2_INVERT_LSB +: NUM_OUT];
         clock_outputs_static <= reset_mode | power_down_active;
      end
   end

   // Quarter-mode shift; with feedback on that divider the other outputs lead
   always_ff @(posedge clock) begin
      if (!resetn) begin
         clock_outputs_shift90     <= '0;
         clock_outputs_ref_aligned <= '1;
      end else if (clock_enable) begin
         clock_outputs_shift90 <= route_reg[NUM_OUT-1:0] & {NUM_OUT{quarter_mode}};
         if (quarter_mode && route_reg[phsc_pkg::ROUTE_FB_P16]) begin
            clock_outputs_ref_aligned <= route_reg[NUM_OUT-1:0];
         end else begin
            clock_outputs_ref_aligned <= '1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Local register port
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         route_reg <= '0;
      end else if (clock_enable && reg_write && reg_addr == phsc_pkg::REG_ROUTE) begin
         route_reg <= reg_wdata[NUM_OUT:0];
      end
   end

   always_comb begin
      rdata_next = '0;
      unique case (reg_addr)
         phsc_pkg::REG_WORD0:  rdata_next = word_reg[0];
         phsc_pkg::REG_WORD1:  rdata_next = word_reg[1];
         phsc_pkg::REG_WORD2:  rdata_next = word_reg[2];
         phsc_pkg::REG_WORD3:  rdata_next = word_reg[3];
         phsc_pkg::REG_STATUS: rdata_next = {24'h00_0000, xfer_drop_reg, ext_hold_reg, ho_state_reg,
                                             reset_mode, power_down_active, cp_tristate, lock_reg};
         phsc_pkg::REG_ROUTE:  rdata_next = {{(31-NUM_OUT){1'b0}}, route_reg};
         default:              rdata_next = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (clock_enable) begin
         reg_rdata <= reg_read ? rdata_next : '0;
      end
   end

endmodule

/* pkg/phsc_pkg.sv */
package phsc_pkg;

   // ---------------------------------------------------------------
   // Serial configuration words
   // ---------------------------------------------------------------
   localparam int          WORD_W        = 32;
   localparam int          NUM_WORDS     = 4;
   localparam int          ADDR_FIELD_W  = 2;
   localparam logic [5:0]  BITS_PER_WORD = 6'h20;
   localparam logic [5:0]  BITCNT_MAX    = 6'h21;

   // Power-up contents of each word; low two bits hold the word's own address
   localparam logic [31:0] WORD0_DEFAULT = 32'h0007_F1FC;
   localparam logic [31:0] WORD1_DEFAULT = 32'h0000_0005;
   localparam logic [31:0] WORD2_DEFAULT = 32'h0000_0002;
   localparam logic [31:0] WORD3_DEFAULT = 32'h0000_0003;

   // Word 1 fields
   localparam int W1_ANALOG_LOCK = 29;
   localparam int W1_P16_DIV4    = 30;
   localparam int W1_P16_DIV8    = 31;
   // Word 2 fields
   localparam int W2_CP_NEGATIVE = 2;
   localparam int W2_CP_PRESET   = 3;
   localparam int W2_DISABLE_LSB = 4;
   localparam int W2_INVERT_LSB  = 14;
   localparam int W2_POWER_DOWN  = 28;
   localparam int W2_PIN_IS_HOLD = 29;
   localparam int W2_SOFT_RESET  = 30;
   localparam int W2_SOFT_HOLD   = 31;
   // Word 3 fields
   localparam int W3_WINDOW_LSB  = 2;
   localparam int W3_COUNT_LSB   = 4;
   localparam int W3_CYCLE_SLIP  = 6;
   localparam int W3_HOLD_FUNC   = 9;
   localparam int W3_HOLD_ALWAYS = 11;

   // ---------------------------------------------------------------
   // Lock detection
   // ---------------------------------------------------------------
   localparam logic [1:0]  WIN_3P5     = 2'h0;
   localparam logic [1:0]  WIN_8P5     = 2'h1;
   localparam logic [1:0]  WIN_18P5    = 2'h2;
   localparam logic [1:0]  WIN_FREQ    = 2'h3;
   // Half widths in ps: an edge is outside beyond half the window
   localparam logic [15:0] HALF_3P5_PS  = 16'h06D6;
   localparam logic [15:0] HALF_8P5_PS  = 16'h1099;
   localparam logic [15:0] HALF_18P5_PS = 16'h2422;
   localparam logic [8:0]  LOCK_CNT_0  = 9'h001;
   localparam logic [8:0]  LOCK_CNT_1  = 9'h010;
   localparam logic [8:0]  LOCK_CNT_2  = 9'h040;
   localparam logic [8:0]  LOCK_CNT_3  = 9'h100;
   localparam logic [6:0]  RELOCK_CYCLES = 7'h40;

   // ---------------------------------------------------------------
   // Local register port
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_WORD0  = 8'h00;
   localparam logic [7:0] REG_WORD1  = 8'h04;
   localparam logic [7:0] REG_WORD2  = 8'h08;
   localparam logic [7:0] REG_WORD3  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_ROUTE  = 8'h14;
   localparam int         ROUTE_FB_P16 = 10;

   typedef enum logic [1:0] {
      HO_IDLE,
      HO_LOCKED,
      HO_HOLD,
      HO_RELOCK
   } phsc_ho_state_t;

endpackage
